/* include/failover_defs.svh */
`ifndef FAILOVER_DEFS_SVH
`define FAILOVER_DEFS_SVH
// boot switch mode encodings
`define MODE_NORMAL 4'h0
`define MODE_NORMAL_EE 4'h1
`define MODE_FO_P0 4'h2
`define MODE_FO_P2 4'h3
`define MODE_EE_FO_P0 4'h4
`define MODE_EE_FO_P2 4'h5
// external port numbers as reported
`define PORT_LOW 2'h0
`define PORT_HIGH 2'h2
// request source bit positions
`define SRC_SW 0
`define SRC_SIG 1
`define SRC_WDT 2
// timing
`define CLK_PERIOD_NS 25
`define TICK_PERIOD_NS 1000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
// edges after reset release before straps are caught
`define STRAP_SETTLE 2'h3
// reset value of the software select field
`define SEL_RESET 1'b0
`endif

/* include/failover_pkg.sv */
package failover_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DOWN, ST_MUX, ST_TRAIN} fo_state_t;
  typedef logic [2:0] src_vec_t;
  typedef logic [3:0] boot_mode_t;
  typedef logic [1:0] port_num_t;
endpackage

/* include/wdog_if.sv */
`timescale 1ns/10ps
interface wdog_if #(parameter int CNT_W = 32) ();
  logic wr;
  logic [CNT_W-1:0] wdata;
  logic [CNT_W-1:0] count;
  logic expire;
  modport ctl (output wr, output wdata, input count, input expire);
  modport tmr (input wr, input wdata, output count, output expire);
endinterface

/* hdl/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  // two stages; only the second stage is visible outside
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule // pin_sync

/* hdl/watchdog_timer.sv */
`timescale 1ns/10ps
`include "failover_defs.svh"
module watchdog_timer #(
  parameter int CNT_W = 32
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  wdog_if.tmr wd
);
  localparam int TICKS = `TICK_CYCLES;
  localparam int DIV_W = $clog2(TICKS);
  logic [DIV_W-1:0] div_q;
  logic tick;
  logic [CNT_W-1:0] cnt_q;
  logic exp_q;

  if (CNT_W < 8 || CNT_W > 32) begin : g_bad_width
    $error("watchdog width must be 8 to 32");
  end

  // microsecond enable from the core clock
  assign tick = (div_q == DIV_W'(TICKS - 1));
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= '0;
    end else if (tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // count and stop
  // a write rearms at once and beats a decrement in the same cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (wd.wr) begin
      cnt_q <= wd.wdata;
    end else if (tick && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // expiry pulse
  // only a decrement from one counts; writing zero never fires
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      exp_q <= 1'b0;
    end else begin
      exp_q <= !wd.wr && tick && cnt_q == CNT_W'(1);
    end
  end

  assign wd.count = cnt_q;
  assign wd.expire = exp_q;

  a_tick_period: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    tick |-> ##40 tick)
    else $error("microsecond tick spacing wrong");
  a_count_holds_zero: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (cnt_q == '0 && !wd.wr) |=> cnt_q == '0)
    else $error("count moved from zero without a write");
  a_expire_cause: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    exp_q |-> $past(cnt_q) == CNT_W'(1) && cnt_q == '0)
    else $error("expiry without a one to zero step");
endmodule // watchdog_timer

/* hdl/upstream_port_failover.sv */
`timescale 1ns/10ps
`include "failover_defs.svh"
module upstream_port_failover
  import failover_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] boot_switch_mode_i,
  input wire logic upstream_select_pin_i,
  input wire logic cfg_sel_wr_i,
  input wire logic cfg_sel_data_i,
  input wire logic smb_sel_wr_i,
  input wire logic smb_sel_data_i,
  input wire logic signal_failover_enable_i,
  input wire logic timer_failover_enable_i,
  input wire logic link_down_hot_reset_disable_i,
  input wire logic wdog_wr_i,
  input wire logic [CNT_W-1:0] wdog_data_i,
  input wire logic change_clear_i,
  output logic ltssm_force_detect_o,
  output logic dl_down_o,
  output logic replay_flush_o,
  output logic queue_flush_o,
  output logic serdes_sel_o,
  output logic link_train_start_o,
  output logic hot_reset_req_o,
  output logic port2_disable_o,
  output logic failover_enabled_flag_o,
  output logic [1:0] current_upstream_port_o,
  output logic upstream_change_sticky_o,
  output logic upstream_change_initiated_o,
  output logic upstream_select_o,
  output logic upstream_select_level_o,
  output logic [CNT_W-1:0] wdog_count_o
);
  logic [4:0] pins_sync;
  boot_mode_t mode_sync;
  logic sel_pin;
  logic [1:0] settle_q;
  logic strap_done_q;
  logic fo_mode_q;
  port_num_t cur_port_q;
  port_num_t target_q;
  port_num_t pin_port;
  logic sel_field_q;
  logic sw_evt;
  logic sig_cond;
  logic wdt_evt;
  src_vec_t raw_req;
  src_vec_t acc_req;
  src_vec_t pend_q;
  src_vec_t inprog_q;
  src_vec_t pick;
  fo_state_t state_q;
  logic force_q;
  logic dl_down_q;
  logic flush_q;
  logic train_q;
  logic hot_rst_q;
  logic sticky_q;
  logic initiated_q;

  wdog_if #(.CNT_W(CNT_W)) wdog ();

  // straps and the select pin come from outside the clock domain
  pin_sync #(.W(5)) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({upstream_select_pin_i, boot_switch_mode_i}),
    .q_o(pins_sync)
  );
  assign mode_sync = pins_sync[3:0];
  assign sel_pin = pins_sync[4];
  assign upstream_select_level_o = sel_pin;
  // low port 0, high port 2
  assign pin_port = sel_pin ? `PORT_HIGH : `PORT_LOW;

  assign wdog.wr = wdog_wr_i;
  assign wdog.wdata = wdog_data_i;
  watchdog_timer #(.CNT_W(CNT_W)) u_watchdog (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .wd(wdog)
  );
  assign wdog_count_o = wdog.count;

  // straps caught after release
  // wait for the synchroniser to fill before trusting the mode pins
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_q <= 2'h0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      settle_q <= settle_q + 2'h1;
      strap_done_q <= (settle_q == `STRAP_SETTLE - 2'h1);
    end
  end

  // only rst_n_i (fundamental reset) clears this; hot reset is not an input
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fo_mode_q <= 1'b0;
    end else if (!strap_done_q && settle_q == `STRAP_SETTLE - 2'h1) begin
      fo_mode_q <= (mode_sync == `MODE_FO_P0) ||
                   (mode_sync == `MODE_FO_P2) ||
                   (mode_sync == `MODE_EE_FO_P0) ||
                   (mode_sync == `MODE_EE_FO_P2);
    end
  end

  // field written by either master
  // configuration wins a same-cycle collision with the management bus
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_field_q <= `SEL_RESET;
    end else if (cfg_sel_wr_i) begin
      sel_field_q <= cfg_sel_data_i;
    end else if (smb_sel_wr_i) begin
      sel_field_q <= smb_sel_data_i;
    end
  end
  assign upstream_select_o = sel_field_q;

  // every source is gated by the strapped mode
  always_comb begin
    sw_evt = 1'b0;
    if (cfg_sel_wr_i) begin
      sw_evt = cfg_sel_data_i != sel_field_q;
    end else if (smb_sel_wr_i) begin
      sw_evt = smb_sel_data_i != sel_field_q;
    end
    sw_evt = sw_evt && fo_mode_q;
  end

  assign sig_cond = fo_mode_q && signal_failover_enable_i &&
                    (pin_port != cur_port_q);
  assign wdt_evt = fo_mode_q && timer_failover_enable_i && wdog.expire;
  assign raw_req = {wdt_evt, sig_cond, sw_evt};

  // same type dropped
  // a source already running or already waiting takes no second request
  assign acc_req = raw_req & ~(inprog_q | pend_q);

  // fixed priority among waiting sources: software, pin, watchdog
  always_comb begin
    pick = 3'h0;
    if (pend_q[`SRC_SW]) begin
      pick[`SRC_SW] = 1'b1;
    end else if (pend_q[`SRC_SIG]) begin
      pick[`SRC_SIG] = 1'b1;
    end else if (pend_q[`SRC_WDT]) begin
      pick[`SRC_WDT] = 1'b1;
    end
  end

  // other type held
  // a new request always waits here; launch happens from idle only
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_q <= 3'h0;
    end else if (state_q == ST_IDLE) begin
      pend_q <= (pend_q & ~pick) | acc_req;
    end else begin
      pend_q <= pend_q | acc_req;
    end
  end

  // failover sequencer
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (pend_q != 3'h0) begin
            state_q <= ST_DOWN;
          end
        end
        ST_DOWN: state_q <= ST_MUX;
        ST_MUX: state_q <= ST_TRAIN;
        ST_TRAIN: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inprog_q <= 3'h0;
    end else if (state_q == ST_IDLE) begin
      inprog_q <= pick;
    end else if (state_q == ST_TRAIN) begin
      inprog_q <= 3'h0;
    end
  end

  // watchdog takes the other port
  // target is fixed at launch so a deferred request uses fresh state
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      target_q <= `PORT_LOW;
    end else if (state_q == ST_IDLE) begin
      if (pick[`SRC_SW]) begin
        target_q <= sel_field_q ? `PORT_HIGH : `PORT_LOW;
      end else if (pick[`SRC_SIG]) begin
        target_q <= pin_port;
      end else begin
        target_q <= (cur_port_q == `PORT_LOW) ? `PORT_HIGH : `PORT_LOW;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      force_q <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      force_q <= (state_q == ST_IDLE) && (pend_q != 3'h0);
      flush_q <= (state_q == ST_IDLE) && (pend_q != 3'h0);
    end
  end

  // link stays down until training on the new port is started
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dl_down_q <= 1'b0;
    end else if (state_q == ST_IDLE && pend_q != 3'h0) begin
      dl_down_q <= 1'b1;
    end else if (state_q == ST_TRAIN) begin
      dl_down_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hot_rst_q <= 1'b0;
    end else begin
      hot_rst_q <= (state_q == ST_IDLE) && (pend_q != 3'h0) &&
                   !link_down_hot_reset_disable_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_port_q <= `PORT_LOW;
    end else if (!strap_done_q && settle_q == `STRAP_SETTLE - 2'h1) begin
      cur_port_q <= (mode_sync == `MODE_FO_P2 ||
                     mode_sync == `MODE_EE_FO_P2) ? `PORT_HIGH : `PORT_LOW;
    end else if (state_q == ST_DOWN) begin
      cur_port_q <= target_q;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      train_q <= 1'b0;
    end else begin
      train_q <= (state_q == ST_MUX);
    end
  end

  // sticky change flag
  // set beats a same-cycle clear so no failover goes unseen
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sticky_q <= 1'b0;
    end else if (state_q == ST_IDLE && pend_q != 3'h0) begin
      sticky_q <= 1'b1;
    end else if (change_clear_i) begin
      sticky_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      initiated_q <= 1'b0;
    end else begin
      initiated_q <= (acc_req != 3'h0) || (pend_q != 3'h0) ||
                     (state_q != ST_IDLE);
    end
  end

  assign ltssm_force_detect_o = force_q;
  assign dl_down_o = dl_down_q;
  assign replay_flush_o = flush_q;
  assign queue_flush_o = flush_q;
  assign hot_reset_req_o = hot_rst_q;
  assign link_train_start_o = train_q;
  assign current_upstream_port_o = cur_port_q;
  assign serdes_sel_o = (cur_port_q == `PORT_HIGH);
  assign failover_enabled_flag_o = fo_mode_q;
  assign port2_disable_o = fo_mode_q;
  assign upstream_change_sticky_o = sticky_q;
  assign upstream_change_initiated_o = initiated_q;

  a_down_on_launch: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_q == ST_IDLE && pend_q != 3'h0) |=>
      ltssm_force_detect_o && dl_down_o && upstream_change_sticky_o)
    else $error("launch did not force the link down");
  a_flush_with_down: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ltssm_force_detect_o |-> replay_flush_o && queue_flush_o)
    else $error("link forced down without flush");
  a_mux_then_train: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ltssm_force_detect_o |-> ##1 (current_upstream_port_o == target_q)
      ##1 link_train_start_o && dl_down_o ##1 !dl_down_o)
    else $error("mux and training order broken");
  a_hot_reset_gate: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ltssm_force_detect_o |->
      hot_reset_req_o == !$past(link_down_hot_reset_disable_i))
    else $error("hot reset request does not follow disable bit");
  a_mode_quiet: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !fo_mode_q |-> state_q == ST_IDLE && pend_q == 3'h0)
    else $error("failover activity outside failover mode");
  a_same_drop: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (inprog_q[`SRC_SW] && state_q != ST_IDLE && !pend_q[`SRC_SW]) |=>
      !pend_q[`SRC_SW])
    else $error("same type request was queued");
  a_defer_other: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_q == ST_DOWN && acc_req[`SRC_WDT]) |=> pend_q[`SRC_WDT]
      ##2 state_q == ST_IDLE ##1 state_q == ST_DOWN)
    else $error("deferred request not run after current one");
  a_pin_failover: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (sig_cond && state_q == ST_IDLE && pend_q == 3'h0) |=>
      pend_q[`SRC_SIG] ##1 ltssm_force_detect_o ##1
      current_upstream_port_o == $past(pin_port, 3))
    else $error("pin failover did not reach the pin port");
endmodule // upstream_port_failover

/* verif/upstream_partner.sv */
`timescale 1ns/10ps
// far end of the upstream link: sees the link drop and retrain
module upstream_partner (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic force_i,
  input wire logic dl_down_i,
  input wire logic train_i,
  input wire logic serdes_sel_i,
  output int trains_o,
  output int order_errs_o,
  output logic lane_o
);
  logic down_q;
  // retrain only after a drop, lanes already switched
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      down_q <= 1'b0;
      trains_o <= 0;
      order_errs_o <= 0;
      lane_o <= 1'b0;
    end else begin
      if (force_i) begin
        down_q <= 1'b1;
      end
      if (train_i) begin
        trains_o <= trains_o + 1;
        lane_o <= serdes_sel_i; // lane seen when training begins
        down_q <= 1'b0;
        // training while the link is still up is a fault
        if (!down_q || !dl_down_i) begin
          order_errs_o <= order_errs_o + 1;
        end
      end
    end
  end
endmodule // upstream_partner

/* verif/upstream_port_failover_tb.sv */
`timescale 1ns/10ps
`include "failover_defs.svh"
`define CHK(n, e, a) check(n, 32'(e), 32'(a))
module upstream_port_failover_tb;
  import failover_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  boot_mode_t mode = `MODE_NORMAL;
  logic pin = 1'b0, cwr = 1'b0, cd = 1'b0, swr = 1'b0, sd = 1'b0;
  logic sig_en = 1'b0, tim_en = 1'b0, hr_dis = 1'b0, wwr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic clr = 1'b0;
  logic frc, dld, rpf, qf, ssel, trn, hrr, p2d, fen, sti, ini, sel, lvl;
  port_num_t cur;
  logic [31:0] cnt;
  int trains, oerr, miscompares = 0, checked = 0, cycles = 0;
  logic lane;
  int t0, m, v;

  upstream_port_failover #(.CNT_W(32)) dut_u (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .boot_switch_mode_i(mode),
    .upstream_select_pin_i(pin), .cfg_sel_wr_i(cwr), .cfg_sel_data_i(cd),
    .smb_sel_wr_i(swr), .smb_sel_data_i(sd),
    .signal_failover_enable_i(sig_en), .timer_failover_enable_i(tim_en),
    .link_down_hot_reset_disable_i(hr_dis), .wdog_wr_i(wwr),
    .wdog_data_i(wdat), .change_clear_i(clr), .ltssm_force_detect_o(frc),
    .dl_down_o(dld), .replay_flush_o(rpf), .queue_flush_o(qf),
    .serdes_sel_o(ssel), .link_train_start_o(trn), .hot_reset_req_o(hrr),
    .port2_disable_o(p2d), .failover_enabled_flag_o(fen),
    .current_upstream_port_o(cur), .upstream_change_sticky_o(sti),
    .upstream_change_initiated_o(ini), .upstream_select_o(sel),
    .upstream_select_level_o(lvl), .wdog_count_o(cnt));

  upstream_partner partner_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .force_i(frc), .dl_down_i(dld), .train_i(trn), .serdes_sel_i(ssel),
    .trains_o(trains), .order_errs_o(oerr), .lane_o(lane));

  // 25 ns clock
  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // hang guard: every scenario together is far below this
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      complete_run();
    end
  end

  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] a);
    checked = checked + 1;
    if (a !== e) begin
      miscompares = miscompares + 1;
      $display("Error %s expected %h seen %h", n, e, a);
    end
  endtask

  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function automatic port_num_t boot_port(input boot_mode_t b);
    return (b == `MODE_FO_P2 || b == `MODE_EE_FO_P2) ? `PORT_HIGH : `PORT_LOW;
  endfunction

  function automatic logic fo_mode(input boot_mode_t b);
    return b >= `MODE_FO_P0 && b <= `MODE_EE_FO_P2;
  endfunction

  // hold fundamental reset, set straps, then release
  task automatic do_reset(input boot_mode_t b);
    @(negedge sys_clk_i);
    rst_n_i = 1'b0;
    mode = b;
    pin = 1'b0;
    sig_en = 1'b0;
    tim_en = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
  endtask

  // one software write followed through the whole failover walk
  task automatic sw_walk(input logic smb, input logic val, input logic dis);
    hr_dis = dis;
    cwr = !smb;
    cd = val;
    swr = smb;
    sd = val;
    @(negedge sys_clk_i);
    cwr = 1'b0;
    swr = 1'b0;
    `CHK("select field", val, sel);
    `CHK("initiated", 1, ini);
    @(negedge sys_clk_i);
    `CHK("force detect", 1, frc & dld);
    `CHK("flushes", 2'b11, {rpf, qf});
    `CHK("hot reset", !dis, hrr);
    `CHK("sticky", 1, sti);
    @(negedge sys_clk_i);
    `CHK("force low", 0, frc);
    `CHK("port", val ? `PORT_HIGH : `PORT_LOW, cur);
    `CHK("lanes", val, ssel);
    @(negedge sys_clk_i);
    `CHK("train", 1, trn);
    @(negedge sys_clk_i);
    `CHK("link back", 2'b00, {trn, dld});
    repeat (3) @(negedge sys_clk_i);
  endtask

  initial begin
    void'($urandom(30));
    // every boot mode plus an unused code
    for (m = 0; m < 7; m++) begin
      do_reset(m == 6 ? 4'h9 : 4'(m));
      `CHK("boot port", boot_port(mode), cur);
      `CHK("boot lanes", boot_port(mode) == `PORT_HIGH, ssel);
      `CHK("fo flag", fo_mode(mode), fen);
      `CHK("port2 off", fo_mode(mode), p2d);
    end
    $display("test boot modes done");
    // controls are dead in a normal mode
    do_reset(`MODE_NORMAL);
    cwr = 1'b1;
    cd = 1'b1;
    sig_en = 1'b1;
    pin = 1'b1;
    @(negedge sys_clk_i);
    cwr = 1'b0;
    repeat (12) @(negedge sys_clk_i);
    `CHK("no fo port", `PORT_LOW, cur);
    `CHK("no fo trains", 0, trains);
    $display("test normal mode done");
    // random software walk, spaced so no write lands mid-failover
    do_reset(`MODE_FO_P0);
    v = 0;
    for (m = 0; m < 8; m++) begin
      t0 = $urandom_range(0, 1);
      if (t0 != v) begin
        sw_walk($urandom_range(0, 1), t0[0], $urandom_range(0, 1));
        v = t0;
      end else begin
        // same value write, no failover expected
        cwr = 1'b1;
        cd = t0[0];
        @(negedge sys_clk_i);
        cwr = 1'b0;
        repeat (8) @(negedge sys_clk_i);
        `CHK("same value", 0, sti | trn | dld);
      end
      clr = 1'b1;
      @(negedge sys_clk_i);
      clr = 1'b0;
      @(negedge sys_clk_i);
      `CHK("sticky clear", 0, sti);
    end
    `CHK("link order", 0, oerr);
    $display("test software failover done");
    // second software write while the first one still waits is lost
    do_reset(`MODE_EE_FO_P0);
    cwr = 1'b1;
    cd = 1'b1;
    @(negedge sys_clk_i);
    cd = 1'b0;
    @(negedge sys_clk_i);
    cwr = 1'b0;
    repeat (15) @(negedge sys_clk_i);
    `CHK("drop port", `PORT_HIGH, cur);
    `CHK("drop trains", 1, trains);
    $display("test same source drop done");
    // pin driven failover, held for long intervals
    do_reset(`MODE_FO_P2);
    // pin is changed rarely, never mid-failover
    pin = 1'b1;
    // let the pin clear its synchroniser before enabling, else the stale
    // low level would look like a request for port 0
    repeat (3) @(negedge sys_clk_i);
    sig_en = 1'b1;
    repeat (12) @(negedge sys_clk_i);
    `CHK("pin same port", 0, trains);
    sig_en = 1'b0;
    pin = 1'b0;
    repeat (12) @(negedge sys_clk_i);
    `CHK("pin level", 0, lvl);
    `CHK("pin disabled", 0, trains);
    sig_en = 1'b1;
    repeat (12) @(negedge sys_clk_i);
    `CHK("pin low port", `PORT_LOW, cur);
    pin = 1'b1;
    repeat (12) @(negedge sys_clk_i);
    `CHK("pin high port", `PORT_HIGH, cur);
    `CHK("pin lane", 1, lane);
    $display("test pin failover done");
    // watchdog expiry during a software failover
    do_reset(`MODE_FO_P0);
    tim_en = 1'b1;
    wwr = 1'b1;
    wdat = 32'h2;
    @(negedge sys_clk_i);
    wwr = 1'b0;
    for (t0 = 0; t0 < 100 && cnt !== 32'h1; t0++) begin
      @(negedge sys_clk_i);
    end
    // write lands so the expiry pulse meets the software run in its down step
    repeat (38) @(negedge sys_clk_i);
    `CHK("count holds", 1, cnt);
    cwr = 1'b1;
    cd = 1'b1;
    @(negedge sys_clk_i);
    cwr = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    `CHK("count zero", 0, cnt);
    repeat (20) @(negedge sys_clk_i);
    `CHK("deferred runs", 2, trains);
    `CHK("opposite port", `PORT_LOW, cur);
    repeat (60) @(negedge sys_clk_i);
    `CHK("count stops", 0, cnt);
    `CHK("no rearm", 2, trains);
    $display("test watchdog defer done");
    complete_run();
  end
endmodule // upstream_port_failover_tb
